/* inc/grant_pipe_pkg.sv */
// Package: constants, types and carriers for the request-to-data grant pipeliner
package grant_pipe_pkg;

  // ********************************************************
  // Transfer-type codes
  // ********************************************************
  localparam logic [2:0] TT_READ_LP = 3'h0;
  localparam logic [2:0] TT_READ_HP = 3'h1;
  localparam logic [2:0] TT_WRITE_LP = 3'h2;
  localparam logic [2:0] TT_WRITE_HP = 3'h3;
  localparam logic [2:0] TT_START = 3'h7;

  // ********************************************************
  // Counts and reset values
  // ********************************************************
  localparam int GNT_IDLE_CLOCKS = 2;
  localparam logic [1:0] GNT_IDLE_CNT_W = 2'h2;
  localparam logic [1:0] IDLE_CNT_RST = 2'h0;
  localparam logic [2:0] TT_RST = 3'h7;

  // Bus activity the arbiter samples each clock
  typedef struct packed {
    logic pipe_n;       // Pipelined-request strobe
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic read_buffer_full_n;
  } bus_obs_s;

  // What kind of transaction is currently on the bus
  typedef struct packed {
    logic is_pci;       // PCI transaction rather than pipelined request
    logic is_write;     // PCI write
    logic core_master;  // Core logic started the PCI transaction
  } cur_txn_s;

  // Pending data request from the memory side
  typedef struct packed {
    logic valid;
    logic is_write;
    logic high_prio;
  } data_req_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_GNT,
    ST_WAIT_START,
    ST_DATA_GNT,
    ST_WAIT_END,
    ST_GAP
  } arb_state_e;

endpackage

/* hdl/gnt_idle_counter.sv */
// Counts clocks since the start-transaction grant was dropped
`timescale 1ns/1ps
`default_nettype none
module gnt_idle_counter
  import grant_pipe_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Grant state
  input wire logic start_gnt,
  output logic idle_done
);

  logic [1:0] cnt_q;

  // ********************************************************
  // Saturating idle counter
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= IDLE_CNT_RST;
    end else if (start_gnt) begin
      cnt_q <= IDLE_CNT_RST;
    end else if (cnt_q != GNT_IDLE_CNT_W) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign idle_done = (cnt_q == GNT_IDLE_CNT_W);

endmodule // gnt_idle_counter
`default_nettype wire

/* hdl/txn_end_detect.sv */
// Detects the end of the current bus transaction
`timescale 1ns/1ps
`default_nettype none
module txn_end_detect
  import grant_pipe_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus view
  input wire bus_obs_s obs,
  output logic bus_busy,
  output logic txn_end
);

  logic busy_q;
  logic busy_now;

  // Busy while any framing, ready or request-strobe line is low
  assign busy_now = !obs.frame_n || !obs.irdy_n || !obs.trdy_n || !obs.pipe_n;

  // ********************************************************
  // Falling edge of activity marks completion
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_now;
    end
  end

  assign bus_busy = busy_now;
  assign txn_end = busy_q && !busy_now;

endmodule // txn_end_detect
`default_nettype wire

/* hdl/grant_pipeliner.sv */
// Core-logic arbiter: pipelines data grants behind a request transaction
//
// Behaviour
// - Grant read return after strobe sampled
// - Turn-around between request and read data
// - No turn-around request to write data
// - Data grant waits strobe, FRAME or idle
// - Write code makes master supply data
// - Start code may linger, costing bandwidth
// - Dead clock between PCI and data
// - Data grant clock after FRAME sampled
// - No low-priority read while buffer full
// - Read data waits for PCI completion
// - Enqueue data grant at earliest clock
// - Master PCI read then write: turn-around
// - Master PCI write then read: AD turn
// - Core write then read: extra clock
// - Core write then write: both turns
// - Master write then write: dead only
// - Long strobe lets write follow directly
// - Write grant once request detected
`timescale 1ns/1ps
`default_nettype none
module grant_pipeliner
  import grant_pipe_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus observation
  input wire bus_obs_s obs,
  input wire cur_txn_s cur,
  // Requests from the master and from the core
  input wire logic master_req,
  input wire data_req_s dreq,
  // Grant to master
  output logic gnt_n,
  output logic [2:0] transfer_type_code,
  // Data phase control toward the core datapath
  output logic data_go,
  output logic data_dir_write,
  output logic ad_turn
);

  arb_state_e state_q;
  logic gnt_n_q;
  logic [2:0] tt_q;
  logic go_q;
  logic dir_q;
  logic turn_q;
  logic [1:0] gap_q;
  logic gap_write_q;
  logic [1:0] gap_need;
  logic idle_done;
  logic bus_busy;
  logic txn_end;
  logic start_gnt;
  logic enq_ok;
  logic read_blocked;
  logic txn_started;

  assign start_gnt = (state_q == ST_START_GNT);

  // ********************************************************
  // Helpers
  // ********************************************************
  gnt_idle_counter u_idle (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start_gnt(start_gnt),
    .idle_done(idle_done)
  );

  txn_end_detect u_end (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .obs(obs),
    .bus_busy(bus_busy),
    .txn_end(txn_end)
  );

  // Request start: strobe or FRAME seen (combinational, so no wasted clock)
  assign txn_started = !obs.pipe_n || !obs.frame_n;
  // Enqueue allowed on start, or after idle grant gap
  assign enq_ok = txn_started || idle_done;
  // Low-priority read blocked while master buffer full
  assign read_blocked = !dreq.is_write && !dreq.high_prio && !obs.read_buffer_full_n;

  // Dead and turn-around clocks needed before data starts
  always_comb begin
    gap_need = 2'h0;
    if (cur.is_pci) begin
      gap_need = 2'h1;
      if (cur.core_master && cur.is_write && !dreq.is_write) begin
        gap_need = 2'h2;
      end
    end
    if (!cur.is_pci && !dreq.is_write) begin
      gap_need = 2'h1;
    end
  end

  // ********************************************************
  // Arbitration state
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (master_req && !bus_busy) begin
            state_q <= ST_START_GNT;
          end else if (dreq.valid && enq_ok && !read_blocked) begin
            state_q <= ST_DATA_GNT;
          end
        end
        ST_START_GNT: begin
          // Start code dropped once the start is seen; lingering only costs time
          if (txn_started && dreq.valid && !read_blocked) begin
            state_q <= ST_DATA_GNT;
          end else if (txn_started) begin
            state_q <= ST_WAIT_START;
          end
        end
        ST_WAIT_START: begin
          if (dreq.valid && enq_ok && !read_blocked) begin
            state_q <= ST_DATA_GNT;
          end else if (!bus_busy) begin
            state_q <= ST_IDLE;
          end
        end
        ST_DATA_GNT: begin
          state_q <= ST_WAIT_END; // grant lasts one clock
        end
        ST_WAIT_END: begin
          if (txn_end || !bus_busy) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_q == 2'h0) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ********************************************************
  // Grant outputs
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gnt_n_q <= 1'b1;
      tt_q <= TT_RST;
    end else begin
      gnt_n_q <= 1'b1;
      tt_q <= TT_START;
      if (state_q == ST_IDLE && master_req && !bus_busy) begin
        gnt_n_q <= 1'b0;
      end else if (state_q == ST_START_GNT && !txn_started) begin
        gnt_n_q <= 1'b0;
      end else if ((state_q == ST_IDLE || state_q == ST_WAIT_START || state_q == ST_START_GNT)
                   && !(state_q == ST_IDLE && master_req && !bus_busy)
                   && dreq.valid && enq_ok && !read_blocked) begin
        gnt_n_q <= 1'b0;
        if (dreq.is_write) begin
          tt_q <= dreq.high_prio ? TT_WRITE_HP : TT_WRITE_LP;
        end else begin
          tt_q <= dreq.high_prio ? TT_READ_HP : TT_READ_LP;
        end
      end
    end
  end

  // ********************************************************
  // Gap counter between transaction end and data
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gap_q <= 2'h0;
      gap_write_q <= 1'b0;
    end else if (state_q == ST_DATA_GNT) begin
      gap_q <= gap_need;
      gap_write_q <= dreq.is_write;
    end else if (state_q == ST_GAP && gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end
  end

  // ********************************************************
  // Data phase control
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      go_q <= 1'b0;
      dir_q <= 1'b0;
      turn_q <= 1'b0;
    end else begin
      go_q <= (state_q == ST_GAP) && (gap_q == 2'h0);
      dir_q <= gap_write_q;
      // AD owner changes: any read, any data after a core-started transaction, or write after master PCI read
      turn_q <= (state_q == ST_GAP) && (gap_q != 2'h0)
                && (!gap_write_q || cur.core_master || (cur.is_pci && !cur.is_write));
    end
  end

  assign gnt_n = gnt_n_q;
  assign transfer_type_code = tt_q;
  assign data_go = go_q;
  assign data_dir_write = dir_q;
  assign ad_turn = turn_q;

  // ********************************************************
  // Checks
  // ********************************************************
  no_lp_full_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!gnt_n_q && tt_q == TT_READ_LP) |-> $past(obs.read_buffer_full_n))
    else $error("lp read granted while full");
  enq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!gnt_n_q && tt_q != TT_START) |-> $past(enq_ok)) else $error("data grant before enqueue allowed");
  one_clk_gnt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DATA_GNT) |=> (state_q == ST_WAIT_END)) else $error("data grant not one clock");
  write_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($past(state_q) == ST_IDLE && state_q == ST_DATA_GNT && $past(dreq.is_write)) |-> tt_q[2:1] == 2'b01)
    else $error("write grant code wrong");
  pci_dead_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DATA_GNT && cur.is_pci) |=> gap_q >= 2'h1) else $error("missing dead clock");
  core_wr_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DATA_GNT && cur.is_pci && cur.core_master && cur.is_write && !dreq.is_write)
    |=> gap_q == 2'h2) else $error("core write to read gap wrong");
  go_after_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(go_q) |-> $past(state_q) == ST_GAP) else $error("data started before completion");
  start_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_START_GNT && txn_started) |=> gnt_n_q || tt_q != TT_START) else $error("start code held");
  cov_read: cover property (@(posedge sys_clk) state_q == ST_DATA_GNT && !dreq.is_write);
  cov_write: cover property (@(posedge sys_clk) state_q == ST_DATA_GNT && dreq.is_write);
  cov_pci: cover property (@(posedge sys_clk) state_q == ST_GAP && cur.is_pci);
  cov_turn: cover property (@(posedge sys_clk) turn_q);
  cov_direct: cover property (@(posedge sys_clk) state_q == ST_START_GNT ##1 state_q == ST_DATA_GNT);

  // ********************************************************
  // Grant shape and gap checks
  // ********************************************************

  // Start grant follows an idle bus request
  start_gnt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_IDLE && master_req && !bus_busy) |=> (!gnt_n_q && tt_q == TT_START))
    else $error("start grant missing");

  // Data grant queued on the very clock the start is seen
  early_grant_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_START_GNT && txn_started && dreq.valid && !read_blocked) |=> state_q == ST_DATA_GNT)
    else $error("data grant not at earliest clock");

  // Data grants are latched by the master, so one clock is enough
  data_one_clk_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!gnt_n_q && tt_q != TT_START) |=> (gnt_n_q || tt_q == TT_START))
    else $error("data grant held");

  // High-priority read code follows the request
  read_hp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DATA_GNT && !$past(dreq.is_write) && $past(dreq.high_prio)) |-> tt_q == TT_READ_HP)
    else $error("read code wrong");

  // Request then write data: same driver, no gap
  req_wr_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DATA_GNT && !cur.is_pci && dreq.is_write) |=> gap_q == 2'h0)
    else $error("gap before direct write");

  // Request then read data: one turn-around
  req_rd_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DATA_GNT && !cur.is_pci && !dreq.is_write) |=> gap_q == 2'h1)
    else $error("read gap wrong");

  // Gap counts down one per clock
  gap_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_GAP && gap_q != 2'h0) |=> gap_q == $past(gap_q) - 2'h1)
    else $error("gap count skipped");

  // Read data always turns the AD bus around
  turn_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_GAP && gap_q != 2'h0 && !gap_write_q) |=> turn_q)
    else $error("no turn before read data");

  // Core write then master write: both sides swap
  core_wr_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_GAP && gap_q != 2'h0 && gap_write_q && cur.core_master) |=> turn_q)
    else $error("no turn core write to write");

  // Master write then its own write data keeps every driver
  same_drv_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_GAP && gap_write_q && !cur.core_master && cur.is_write) |=> !turn_q)
    else $error("needless turn-around");

  // Turn-around shown only inside the gap
  turn_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    turn_q |-> $past(state_q) == ST_GAP)
    else $error("turn outside gap");

  // Completion must be seen before the data phase
  wait_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_WAIT_END && bus_busy && !txn_end) |=> state_q == ST_WAIT_END)
    else $error("left wait before completion");

  // Data start is a single pulse
  go_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go_q |=> !go_q)
    else $error("data start longer than a clock");

  // Direction at data start matches the granted code
  dir_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(go_q) |-> dir_q == gap_write_q)
    else $error("data direction wrong");

endmodule // grant_pipeliner
`default_nettype wire

/* tb/gfx_master_model.sv */
// Partner model: graphics master driving the strobe and PCI control lines
`timescale 1ns/1ps
`default_nettype none
module gfx_master_model
  import grant_pipe_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Grant from the arbiter
  input wire logic gnt_n,
  input wire logic [2:0] transfer_type_code,
  // Commands from the bench
  input wire logic go,
  input wire logic use_pci,
  input wire logic by_core,
  input wire logic rbf_full,
  // Lines seen by the arbiter, and the write-grant count for the bench
  output var bus_obs_s obs,
  output var int wr_grants
);
  // ********************************************************
  // Transaction sequencing
  // ********************************************************
  int cnt = 0;

  // Start only on a start grant, a core transfer needs none
  always @(negedge sys_clk) begin
    if (cnt == 0 && go && (by_core || (!gnt_n && transfer_type_code == TT_START))) begin
      cnt = 3;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end
  end

  // Strobe held two clocks so a write grant can pipeline; pull-ups idle high
  assign obs = '{pipe_n: !(cnt > 1 && !use_pci),
                 frame_n: !(cnt == 3 && use_pci),
                 irdy_n: !(cnt > 1 && use_pci),
                 trdy_n: !(cnt > 1 && use_pci),
                 read_buffer_full_n: !rbf_full};

  // Write grants are latched and owed once the current transfer ends
  initial wr_grants = 0;
  always @(posedge sys_clk) begin
    if (!gnt_n && transfer_type_code[2:1] == 2'b01) begin
      wr_grants <= wr_grants + 1;
    end
  end
endmodule // gfx_master_model
`default_nettype wire

/* tb/grant_pipelining_request_to_data_bench.sv */
// Bench: request-to-data grant scenarios against the master model
`timescale 1ns/1ps
`default_nettype none
module grant_pipelining_request_to_data_bench
  import grant_pipe_pkg::*;
;
  logic sys_clk = 0;
  logic rst_b = 0;
  cur_txn_s cur = '0;
  data_req_s dreq = '0;
  logic master_req = 0, go = 0, use_pci = 0, by_core = 0, rbf_full = 0;
  bus_obs_s obs;
  logic gnt_n, data_go, data_dir_write, ad_turn;
  logic [2:0] tt, code;
  int wr_grants, fail_count = 0, total_checks = 0, cyc = 0, d_rw, d_mwr, d;
  bit turn;

  grant_pipeliner u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .obs(obs), .cur(cur), .master_req(master_req),
    .dreq(dreq), .gnt_n(gnt_n), .transfer_type_code(tt), .data_go(data_go), .data_dir_write(data_dir_write),
    .ad_turn(ad_turn));
  gfx_master_model u_master (.sys_clk(sys_clk), .gnt_n(gnt_n), .transfer_type_code(tt), .go(go),
    .use_pci(use_pci), .by_core(by_core), .rbf_full(rbf_full), .obs(obs), .wr_grants(wr_grants));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard, far above the few hundred clocks the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // ********************************************************
  // One transaction, then a data request behind it
  // ********************************************************
  task automatic xfer(input bit pci, wr, core, dwr, hp, output int dl, output bit tn, output logic [2:0] cd);
    int n, te, tg, tgn, ts;
    bit got, want;
    want = !(rbf_full && !dwr && !hp);
    cur = '{pci, wr, core};
    use_pci = pci;
    by_core = core;
    master_req = !core;
    go = 1;
    // A master request carries its data request from the start, so the grant can pipeline
    if (!core) dreq = '{1'b1, dwr, hp};
    ts = -1;
    te = -1;
    tg = -1;
    tgn = 99;
    tn = 0;
    cd = '0;
    got = 0;
    for (n = 0; n < 40 && tg < 0; n++) begin
      @(negedge sys_clk);
      if (ts < 0 && !(obs.pipe_n && obs.frame_n && obs.irdy_n)) begin
        ts = n;
        master_req = 0;
        go = 0;
        if (!got) dreq = '{1'b1, dwr, hp};
      end
      if (!got && gnt_n === 1'b0 && tt !== TT_START) begin
        got = 1;
        cd = tt;
        tgn = n - ts;
        dreq.valid = 0;
      end
      if (ts >= 0 && te < 0 && obs.pipe_n && obs.frame_n && obs.irdy_n) te = n;
      if (ad_turn === 1'b1) tn = 1;
      if (data_go === 1'b1) tg = n;
    end
    dreq.valid = 0;
    master_req = 0;
    go = 0;
    dl = tg - te;
    if (want) begin
      chk(got && ts >= 0 && tgn <= 2, "data grant late after strobe or frame");
      chk(tg >= 0 && te >= 0 && tg >= te, "data phase missing or before end");
      chk(data_dir_write === dwr, "data direction");
    end else begin
      chk(!got && tg < 0, "low priority read granted while buffer full");
    end
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic t_req_read();
    xfer(0, 0, 0, 0, 0, d, turn, code);
    chk(code === TT_READ_LP, "read return code");
    chk(turn, "no turn-around before read data");
  endtask

  task automatic t_req_write();
    int n;
    n = wr_grants;
    xfer(0, 0, 0, 1, 0, d, turn, code);
    d_rw = d;
    chk(code === TT_WRITE_LP, "write supply code");
    chk(!turn && d_rw >= 0, "turn-around with same driver");
    chk(wr_grants == n + 1, "write grant not seen by master");
  endtask

  // Start grant held without a strobe must block the data grant
  task automatic t_hold();
    master_req = 1;
    dreq = '{1'b1, 1'b1, 1'b1};
    repeat (6) @(negedge sys_clk);
    chk(gnt_n === 1'b0 && tt === TT_START, "data grant under a standing start grant");
    xfer(0, 0, 0, 1, 1, d, turn, code);
    chk(code === TT_WRITE_HP, "high priority write code");
  endtask

  task automatic t_rbf();
    rbf_full = 1;
    xfer(0, 0, 0, 0, 0, d, turn, code);
    xfer(0, 0, 0, 0, 1, d, turn, code);
    chk(code === TT_READ_HP, "high priority read refused");
    rbf_full = 0;
  endtask

  task automatic t_pci_master();
    xfer(1, 0, 0, 1, 0, d, turn, code);
    chk(turn, "PCI read to write data needs turn-around");
    xfer(1, 1, 0, 0, 0, d, turn, code);
    d_mwr = d;
    chk(turn, "PCI write to read data needs turn-around");
    xfer(1, 1, 0, 1, 0, d, turn, code);
    chk(!turn && d > d_rw, "same-master write needs dead clock only");
  endtask

  task automatic t_pci_core();
    xfer(1, 1, 1, 0, 0, d, turn, code);
    chk(d > d_mwr, "core write to read data lacks extra clock");
    xfer(1, 1, 1, 1, 0, d, turn, code);
    chk(turn, "core write to write data needs turn-around");
  endtask

  // Main sequence: reset for three clocks, then every scenario
  initial begin
    repeat (3) @(negedge sys_clk);
    chk(gnt_n === 1'b1 && tt === TT_RST && data_go === 1'b0, "outputs in reset");
    rst_b = 1;
    t_req_read();
    t_req_write();
    t_hold();
    t_rbf();
    t_pci_master();
    t_pci_core();
    close_out();
  end
endmodule // grant_pipelining_request_to_data_bench
`default_nettype wire
